/* File: smc_pkg.sv */
// constants, mode codes and reset values for the slave interrupt/timer block
// assumes a single 200 MHz system clock standing in for the oscillator
package smc_pkg;

    // ****************************************************
    // cycle timing
    // ****************************************************
    localparam int unsigned OSC_PER_STATE = 3;   // oscillator clocks per state
    localparam int unsigned STATES_PER_MC = 5;   // states per machine cycle
    localparam int unsigned TMR_PRESCALE  = 32;  // machine cycles per timer tick
    localparam int unsigned EVENT_MIN_MC  = 3;   // least machine cycles between events
    localparam int unsigned TMR_WIDTH     = 8;   // timer/event counter width

    // ****************************************************
    // vectors, pin indices, reset values
    // ****************************************************
    localparam logic [2:0] VEC_EXT    = 3'h3;
    localparam logic [2:0] VEC_TMR    = 3'h7;
    localparam int unsigned PIN_CS_N   = 0;
    localparam int unsigned PIN_WR_N   = 1;
    localparam int unsigned PIN_RD_N   = 2;
    localparam int unsigned PIN_A0     = 3;
    localparam int unsigned PIN_DMA_ACKNOWLEDGE_N_N = 4;
    localparam int unsigned PIN_T1     = 5;
    localparam int unsigned PIN_SS_N   = 6;
    localparam int unsigned PIN_N      = 7;
    localparam logic [6:0] RST_PINS   = 7'h77;   // idle pin levels
    localparam logic       RST_OFF    = 1'b0;    // enables, flags, modes after reset

    // timer input source, one-hot
    typedef enum logic [2:0] {
        TM_STOP  = 3'b001,
        TM_EVENT = 3'b010,
        TM_TIMER = 3'b100
    } smc_tmode_e;

endpackage

/* File: smc_irq_timer.sv */
// interrupt unit, timer/event counter, cycle divider, single step, dma and flag pins
// assumes instruction strobes come from the core on sys_clk_i as one-cycle pulses
// Operation
// - host write sets ext pending and input-full
// - sample per machine cycle, call address 3
// - single level; rearm at return second cycle
// - timer overflow held pending while in service
// - simultaneous: external first, timer kept
// - enabled timer overflow calls address 7
// - disabled timer overflow only sets flag
// - external held during timer service
// - 8-bit counter loadable, survives reset
// - ff increment wraps, flags, requests interrupt
// - timer flag cleared by jump or reset
// - event mode counts test1 falls, spaced
// - timer mode ticks every 32 cycles
// - divide by three, five states per cycle
// - reset disables, stops, clears flags
// - single-step low halts after instruction
// - dma mode: port bit6 is request
// - request cleared by acked access, enable
// - port bit7 acknowledge acts as select
// - flag mode: bits4,5 show buffer flags
// - special pin functions off after reset
// - output-full set by core, cleared host read
// - input-full set by host, cleared core read
`timescale 1ns/1ps

module smc_irq_timer #(
    parameter int unsigned CNT_W = smc_pkg::TMR_WIDTH
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // host bus pins, asynchronous
    input  wire logic             host_cs_n_i,
    input  wire logic             host_wr_n_i,
    input  wire logic             host_rd_n_i,
    input  wire logic             host_a0_i,
    input  wire logic             port2_bit7_i,
    input  wire logic             test1_count_input_i,
    input  wire logic             single_step_n_i,
    // core instruction strobes
    input  wire logic             insn_done_i,
    input  wire logic             en_ext_irq_i,
    input  wire logic             dis_ext_irq_i,
    input  wire logic             en_tmr_irq_i,
    input  wire logic             dis_tmr_irq_i,
    input  wire logic             start_event_counting_i,
    input  wire logic             start_timing_i,
    input  wire logic             stop_count_i,
    input  wire logic             jump_on_timer_flag_i,
    input  wire logic             return_restore_status_i,
    input  wire logic             timer_load_i,
    input  wire logic [CNT_W-1:0] timer_load_val_i,
    input  wire logic             en_dma_i,
    input  wire logic             en_flags_i,
    input  wire logic             obuf_write_i,
    input  wire logic             ibuf_read_i,
    input  wire logic             port2_write_i,
    input  wire logic [7:0]       port2_latch_i,
    // core side results
    output logic                  irq_call_o,
    output logic [2:0]            irq_vector_o,
    output logic                  in_service_o,
    output logic                  halt_o,
    output logic                  sync_o,
    output logic [CNT_W-1:0]      timer_count_o,
    output logic                  timer_overflow_flag_o,
    output logic                  input_buffer_full_flag_o,
    output logic                  output_buffer_full_flag_o,
    // port2 pin outputs
    output logic                  port2_bit4_o,
    output logic                  port2_bit5_o,
    output logic                  port2_bit6_o
);

    // ****************************************************
    // state
    // ****************************************************
    if (CNT_W != smc_pkg::TMR_WIDTH) begin : g_bad_width
        $error("counter width must be 8");
    end

    typedef struct packed {
        logic [6:0]          s1;
        logic [6:0]          s2;
        logic [1:0]          osc;
        logic [2:0]          st;
        logic [4:0]          pre;
        logic [1:0]          ev_hold;
        logic                t1_prev;
        logic                wr_prev;
        logic                rd_prev;
        smc_pkg::smc_tmode_e tmode;
        logic                ext_en;
        logic                tmr_en;
        logic                tf;
        logic                ext_pend;
        logic                tmr_pend;
        logic                req_seen;
        logic                in_srv;
        logic                call;
        logic [2:0]          vec;
        logic                halt;
        logic                sync;
        logic                input_buffer_full_flag;
        logic                output_buffer_full_flag;
        logic                dma_mode;
        logic                flag_mode;
        logic                dma_request_out;
        logic [2:0]          p2o;
    } smc_state_s;

    localparam smc_state_s ST_RST = '{
        s1: smc_pkg::RST_PINS, s2: smc_pkg::RST_PINS, osc: 2'h0, st: 3'h0, pre: 5'h0,
        ev_hold: 2'h0, t1_prev: 1'b1, wr_prev: 1'b0, rd_prev: 1'b0, tmode: smc_pkg::TM_STOP,
        ext_en: smc_pkg::RST_OFF, tmr_en: smc_pkg::RST_OFF, tf: smc_pkg::RST_OFF,
        ext_pend: 1'b0, tmr_pend: 1'b0, req_seen: 1'b0, in_srv: 1'b0, call: 1'b0,
        vec: 3'h0, halt: 1'b0, sync: 1'b1, input_buffer_full_flag: smc_pkg::RST_OFF, output_buffer_full_flag: smc_pkg::RST_OFF,
        dma_mode: smc_pkg::RST_OFF, flag_mode: smc_pkg::RST_OFF, dma_request_out: 1'b0, p2o: 3'h7};

    smc_state_s       st_q;
    smc_state_s       st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             st_en;
    logic             mc_tick;
    logic             host_sel;
    logic             wr_fall;
    logic             rd_fall;
    logic             dma_ack;
    logic             t1_fall;
    logic             inc;
    logic             ovf;
    logic             take;
    logic             take_ext;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_d = st_q;
        // two-flop pin synchronisers
        st_d.s1 = {single_step_n_i, test1_count_input_i, port2_bit7_i, host_a0_i,
                   host_rd_n_i, host_wr_n_i, host_cs_n_i};
        st_d.s2 = st_q.s1;

        // oscillator / 3 gives states, 5 states a machine cycle
        st_en   = (st_q.osc == 2'(smc_pkg::OSC_PER_STATE - 1));
        mc_tick = st_en && (st_q.st == 3'(smc_pkg::STATES_PER_MC - 1)) && !st_q.halt;
        st_d.osc = st_en ? 2'h0 : st_q.osc + 2'h1;
        if (st_en) begin
            st_d.st = (st_q.st == 3'(smc_pkg::STATES_PER_MC - 1)) ? 3'h0 : st_q.st + 3'h1;
        end

        // host strobes; acknowledge selects alongside chip select in dma mode
        host_sel = !st_q.s2[smc_pkg::PIN_CS_N]
                 || (st_q.dma_mode && !st_q.s2[smc_pkg::PIN_DMA_ACKNOWLEDGE_N_N]);
        dma_ack  = st_q.dma_mode && !st_q.s2[smc_pkg::PIN_DMA_ACKNOWLEDGE_N_N];
        st_d.wr_prev = host_sel && !st_q.s2[smc_pkg::PIN_WR_N];
        st_d.rd_prev = host_sel && !st_q.s2[smc_pkg::PIN_RD_N];
        wr_fall = st_d.wr_prev && !st_q.wr_prev;
        rd_fall = st_d.rd_prev && !st_q.rd_prev;

        // buffer flags, set beats clear
        if (wr_fall) begin
            st_d.input_buffer_full_flag = 1'b1;
        end else if (ibuf_read_i) begin
            st_d.input_buffer_full_flag = 1'b0;
        end
        if (obuf_write_i) begin
            st_d.output_buffer_full_flag = 1'b1;
        end else if (rd_fall && !st_q.s2[smc_pkg::PIN_A0]) begin
            st_d.output_buffer_full_flag = 1'b0;
        end

        // count source select
        if (start_event_counting_i) begin
            st_d.tmode = smc_pkg::TM_EVENT;
        end else if (start_timing_i) begin
            st_d.tmode = smc_pkg::TM_TIMER;
        end else if (stop_count_i) begin
            st_d.tmode = smc_pkg::TM_STOP;
        end

        // event sampling once a machine cycle, spaced by a hold-off
        t1_fall = 1'b0;
        if (mc_tick) begin
            st_d.t1_prev = st_q.s2[smc_pkg::PIN_T1];
            st_d.pre     = st_q.pre + 5'h1;
            if (st_q.ev_hold != 2'h0) begin
                st_d.ev_hold = st_q.ev_hold - 2'h1;
            end else if (st_q.t1_prev && !st_q.s2[smc_pkg::PIN_T1]) begin
                t1_fall      = 1'b1;
                st_d.ev_hold = 2'(smc_pkg::EVENT_MIN_MC - 1);
            end
        end
        case (st_q.tmode)
            smc_pkg::TM_EVENT: inc = t1_fall;
            smc_pkg::TM_TIMER: inc = mc_tick && (st_q.pre == 5'(smc_pkg::TMR_PRESCALE - 1));
            smc_pkg::TM_STOP:  inc = 1'b0;
            default:           inc = 1'b0;
        endcase

        // counter: load wins, wrap at ff
        ovf   = inc && (cnt_q == {CNT_W{1'b1}}) && !timer_load_i;
        cnt_d = timer_load_i ? timer_load_val_i : (inc ? cnt_q + 1'b1 : cnt_q);

        // enable flip-flops
        if (en_ext_irq_i) st_d.ext_en = 1'b1;
        if (dis_ext_irq_i) st_d.ext_en = 1'b0;
        if (en_tmr_irq_i) st_d.tmr_en = 1'b1;
        if (dis_tmr_irq_i) st_d.tmr_en = 1'b0;

        // timer flag, overflow beats jump clear
        if (ovf) begin
            st_d.tf = 1'b1;
        end else if (jump_on_timer_flag_i) begin
            st_d.tf = 1'b0;
        end

        // vectored call at instruction end, external first
        take     = insn_done_i && st_q.req_seen && !st_q.in_srv && !st_q.halt;
        take_ext = st_q.ext_pend && st_q.ext_en;
        st_d.call = take;
        if (take) begin
            st_d.vec      = take_ext ? smc_pkg::VEC_EXT : smc_pkg::VEC_TMR;
            st_d.in_srv   = 1'b1;
            st_d.req_seen = 1'b0;
        end else if (mc_tick) begin
            st_d.req_seen = !st_q.in_srv
                          && ((st_q.ext_pend && st_q.ext_en) || st_q.tmr_pend);
        end
        if (return_restore_status_i) begin
            st_d.in_srv = 1'b0;
        end

        // pending latches; new requests beat the clear
        if (wr_fall) begin
            st_d.ext_pend = 1'b1;
        end else if (take && take_ext) begin
            st_d.ext_pend = 1'b0;
        end
        if (!st_q.tmr_en) begin
            st_d.tmr_pend = 1'b0;
        end else if (ovf) begin
            st_d.tmr_pend = 1'b1;
        end else if (take && !take_ext) begin
            st_d.tmr_pend = 1'b0;
        end

        // single step halt and cycle sync
        if (st_q.halt && st_q.s2[smc_pkg::PIN_SS_N]) begin
            st_d.halt = 1'b0;
        end else if (insn_done_i && !st_q.s2[smc_pkg::PIN_SS_N]) begin
            st_d.halt = 1'b1;
        end
        st_d.sync = st_d.halt || (st_d.st == 3'h0);

        // special port2 functions
        if (en_dma_i) st_d.dma_mode = 1'b1;
        if (en_flags_i) st_d.flag_mode = 1'b1;
        if (st_q.dma_mode && port2_write_i && port2_latch_i[6]) begin
            st_d.dma_request_out = 1'b1;
        end else if (en_dma_i || (dma_ack && (rd_fall || wr_fall))) begin
            st_d.dma_request_out = 1'b0;
        end
        st_d.p2o[0] = st_d.flag_mode ? (port2_latch_i[4] && st_d.output_buffer_full_flag) : port2_latch_i[4];
        st_d.p2o[1] = st_d.flag_mode ? (port2_latch_i[5] && !st_d.input_buffer_full_flag) : port2_latch_i[5];
        st_d.p2o[2] = st_d.dma_mode ? st_d.dma_request_out : port2_latch_i[6];
    end

    // ****************************************************
    // registers
    // ****************************************************
    // control state, cleared by reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // count value survives reset
    always_ff @(posedge sys_clk_i) begin
        cnt_q <= cnt_d;
    end

    // outputs straight from flops
    assign irq_call_o                = st_q.call;
    assign irq_vector_o              = st_q.vec;
    assign in_service_o              = st_q.in_srv;
    assign halt_o                    = st_q.halt;
    assign sync_o                    = st_q.sync;
    assign timer_count_o             = cnt_q;
    assign timer_overflow_flag_o     = st_q.tf;
    assign input_buffer_full_flag_o  = st_q.input_buffer_full_flag;
    assign output_buffer_full_flag_o = st_q.output_buffer_full_flag;
    assign port2_bit4_o              = st_q.p2o[0];
    assign port2_bit5_o              = st_q.p2o[1];
    assign port2_bit6_o              = st_q.p2o[2];

    // ****************************************************
    // checks
    // ****************************************************
    sequence s_take_ext;
        take && take_ext;
    endsequence
    sequence s_call_ext;
        st_q.call && (st_q.vec == smc_pkg::VEC_EXT);
    endsequence

    AST_EXT_VECTOR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_take_ext |=> s_call_ext) else $error("external call not to address 3");
    AST_ONE_LEVEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_q.call |-> !$past(st_q.in_srv)) else $error("nested interrupt taken");
    AST_TMR_VECTOR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (take && !take_ext) |=> (st_q.vec == smc_pkg::VEC_TMR) && st_q.in_srv)
        else $error("timer call not to address 7");
    AST_TMR_KEPT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (take && take_ext && st_q.tmr_pend && st_q.tmr_en) |=> st_q.tmr_pend)
        else $error("timer request lost behind external");
    AST_TMR_DISABLED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !st_q.tmr_en |=> !st_q.tmr_pend) else $error("disabled timer held");
    AST_WRAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ovf |=> (cnt_q == '0) && st_q.tf) else $error("overflow wrap or flag wrong");
    AST_TF_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (jump_on_timer_flag_i && !ovf) |=> !st_q.tf) else $error("timer flag not cleared");
    AST_EVENT_SPACING: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        t1_fall |=> (st_q.ev_hold == 2'(smc_pkg::EVENT_MIN_MC - 1))) else $error("event spacing");
    AST_STATE_DIV: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_en |=> !st_en ##1 !st_en ##1 st_en) else $error("state clock not divide by three");
    AST_DRQ_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (en_dma_i && !port2_write_i) |=> !st_q.dma_request_out) else $error("dma request not cleared");
    AST_IBF_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_fall |=> st_q.input_buffer_full_flag && st_q.ext_pend) else $error("host write not flagged");
    AST_HALT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (insn_done_i && !st_q.s2[smc_pkg::PIN_SS_N] && !st_q.halt) |=> st_q.halt && st_q.sync)
        else $error("no halt after instruction");

endmodule

/* File: smc_host_model.sv */
// host cpu, dma controller and single-step flip-flop facing the slave block
// assumes the bench calls its tasks; pins change only just after rising edges
`timescale 1ns/1ps
module smc_host_model (
    // clock and cycle sync
    input  wire logic clk_i,
    input  wire logic sync_i,
    // host bus, acknowledge and step pins
    output logic      cs_n_o,
    output logic      wr_n_o,
    output logic      rd_n_o,
    output logic      a0_o,
    output logic      dma_acknowledge_n_n_o,
    output logic      step_n_o
);
    // ****************************************************
    // idle levels, strobes and acknowledge pulled up, a0 low, step in run mode
    // ****************************************************
    initial begin
        {cs_n_o, wr_n_o, rd_n_o, dma_acknowledge_n_n_o, step_n_o} = 5'h1f;
        a0_o = 1'b0;
    end

    // one access, strobe held four clocks low and four high
    task automatic access(input logic wr, input logic dma, input logic adr);
        @(posedge clk_i);
        a0_o     <= adr;
        cs_n_o   <= dma;                  // dma selects by acknowledge alone
        dma_acknowledge_n_n_o <= ~dma;
        wr_n_o   <= ~wr;                  // select plus write strobe
        rd_n_o   <= wr;
        repeat (4) @(posedge clk_i);
        {cs_n_o, wr_n_o, rd_n_o, dma_acknowledge_n_n_o} <= 4'hf;
        a0_o     <= ~adr;                 // released address shows no stale value
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    // step pin level
    task automatic set_step(input logic v);
        @(posedge clk_i);
        step_n_o <= v;
    endtask

    // release for one instruction, lower again once sync drops
    task automatic release_step();
        int k;
        @(posedge clk_i);
        step_n_o <= 1'b1;
        for (k = 0; k < 100 && sync_i !== 1'b0; k++) begin
            @(posedge clk_i);
        end
        step_n_o <= 1'b0;
    endtask
endmodule

/* File: slave_mcu_interrupt_timer_dma_bench.sv */
// self-checking bench for the slave interrupt, timer, dma and flag logic
// assumes the host model drives the bus pins and the single-step pin
`timescale 1ns/1ps
module slave_mcu_interrupt_timer_dma_bench;
    // ****************************************************
    // signals
    // ****************************************************
    localparam int EN_EXT = 0, DIS_EXT = 1, EN_TMR = 2, DIS_TMR = 3, EVT = 4, TMR = 5, STOP = 6, FLAG_JMP = 7;
    localparam int RET_ST = 8, LOAD = 9, EN_DMA = 10, EN_FLG = 11, OB_WR = 12, IB_RD = 13, P2_WR = 14;
    logic        clk = 1'b0, rst = 1'b1, run = 1'b0, done_q = 1'b0, ev_pin = 1'b1;
    logic [14:0] st  = 15'h0000;
    logic [7:0]  ld  = 8'h00, lat = 8'hff, cnt;
    logic [2:0]  vec;
    logic        cs_n, wr_n, rd_n, a0, ack_n, step_n, call, ins, halt, sync, tflag, in_full, out_full, p4, p5, p6;
    int          fails = 0, cmp_count = 0, cyc = 0, n;

    // clock, insn done one cycle behind run, hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) done_q <= run;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            print_verdict();
        end
    end

    smc_irq_timer u_dut (
        .sys_clk_i(clk), .rst_i(rst), .host_cs_n_i(cs_n), .host_wr_n_i(wr_n), .host_rd_n_i(rd_n),
        .host_a0_i(a0), .port2_bit7_i(ack_n), .test1_count_input_i(ev_pin), .single_step_n_i(step_n),
        .insn_done_i(done_q), .en_ext_irq_i(st[0]), .dis_ext_irq_i(st[1]), .en_tmr_irq_i(st[2]),
        .dis_tmr_irq_i(st[3]), .start_event_counting_i(st[4]), .start_timing_i(st[5]), .stop_count_i(st[6]),
        .jump_on_timer_flag_i(st[7]), .return_restore_status_i(st[8]), .timer_load_i(st[9]),
        .timer_load_val_i(ld), .en_dma_i(st[10]), .en_flags_i(st[11]), .obuf_write_i(st[12]),
        .ibuf_read_i(st[13]), .port2_write_i(st[14]), .port2_latch_i(lat), .irq_call_o(call),
        .irq_vector_o(vec), .in_service_o(ins), .halt_o(halt), .sync_o(sync), .timer_count_o(cnt),
        .timer_overflow_flag_o(tflag), .input_buffer_full_flag_o(in_full), .output_buffer_full_flag_o(out_full),
        .port2_bit4_o(p4), .port2_bit5_o(p5), .port2_bit6_o(p6));
    smc_host_model u_host (.clk_i(clk), .sync_i(sync), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .a0_o(a0), .dma_acknowledge_n_n_o(ack_n), .step_n_o(step_n));

    // ****************************************************
    // tasks
    // ****************************************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        st[i] <= 1'b1;
        @(posedge clk);
        st[i] <= 1'b0;
        tick(1);
    endtask
    task automatic load(input logic [7:0] v);
        @(posedge clk);
        ld <= v;
        pulse(LOAD);
    endtask
    task automatic one_insn();
        @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        tick(2);
    endtask
    // low longer than a machine cycle, high past the three-cycle hold-off
    task automatic fall();
        @(posedge clk);
        ev_pin <= 1'b0;
        repeat (20) @(posedge clk);
        ev_pin <= 1'b1;
        tick(50);
    endtask
    task automatic wcnt(input logic [7:0] v);
        for (n = 0; n < 600 && cnt !== v; n++) tick(1);
    endtask
    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick(2);
    endtask
    // run instructions for a while; ev zero means no call may come
    task automatic wcall(input logic [2:0] ev);
        logic got;
        got = 1'b0;
        @(posedge clk);
        run <= 1'b1;
        for (int k = 0; k < 80 && !got; k++) begin
            tick(1);
            if (call === 1'b1) begin
                got = 1'b1;
                chk("vector", ev, vec);
                chk("in service", 1, ins);
            end
        end
        @(posedge clk);
        run <= 1'b0;
        chk("call taken", ev != 3'h0, got);
    endtask
    task automatic fin(input string nm);
        $display("test %s done, %0d mismatches", nm, fails);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("flags after reset", 16'h0000, {tflag, in_full, out_full, ins, halt, call});
        chk("pins after reset", 16'h0007, {p4, p5, p6});
        load(8'h5a);
        pulse(TMR);
        reset_dut();
        tick(500);
        chk("count kept and stopped", 16'h005a, cnt);
        fin("reset");
        pulse(EN_EXT);
        u_host.access(1'b1, 1'b0, 1'b1);
        chk("input full", 1, in_full);
        wcall(smc_pkg::VEC_EXT);
        u_host.access(1'b1, 1'b0, 1'b0);
        wcall(3'h0);
        pulse(RET_ST);
        wcall(smc_pkg::VEC_EXT);
        pulse(RET_ST);
        wcall(3'h0);
        pulse(DIS_EXT);
        fin("external");
        pulse(EN_FLG);
        chk("input full pin", 0, p5);
        pulse(IB_RD);
        chk("input full cleared", 16'h0001, {in_full, p5});
        pulse(OB_WR);
        chk("output full", 16'h0003, {out_full, p4});
        @(posedge clk) lat <= 8'hef;
        tick(2);
        chk("output full pin masked", 0, p4);
        @(posedge clk) lat <= 8'hff;
        u_host.access(1'b0, 1'b0, 1'b0);
        chk("output full after read", 16'h0000, {out_full, p4});
        fin("flags");
        pulse(EN_TMR);
        load(8'hff);
        pulse(TMR);
        wcnt(8'h00);
        chk("flag at wrap", 1, tflag);
        wcnt(8'h01);
        chk("tick spacing", smc_pkg::TMR_PRESCALE * smc_pkg::OSC_PER_STATE * smc_pkg::STATES_PER_MC, n);
        wcall(smc_pkg::VEC_TMR);
        pulse(FLAG_JMP);
        chk("flag cleared", 0, tflag);
        pulse(RET_ST);
        pulse(STOP);
        pulse(DIS_TMR);
        pulse(EVT);
        load(8'hfe);
        fall();
        fall();
        tick(60);
        chk("masked overflow", 16'h0001, {cnt, tflag});
        wcall(3'h0);
        fall();
        tick(60);
        chk("event count", 1, cnt);
        pulse(FLAG_JMP);
        fin("timer");
        pulse(EN_EXT);
        pulse(EN_TMR);
        load(8'hff);
        @(posedge clk) ev_pin <= 1'b0;
        u_host.access(1'b1, 1'b0, 1'b0);
        tick(10);
        @(posedge clk) ev_pin <= 1'b1;
        tick(30);
        wcall(smc_pkg::VEC_EXT);
        wcall(3'h0);
        pulse(RET_ST);
        wcall(smc_pkg::VEC_TMR);
        u_host.access(1'b1, 1'b0, 1'b0);
        wcall(3'h0);
        pulse(RET_ST);
        wcall(smc_pkg::VEC_EXT);
        pulse(RET_ST);
        pulse(DIS_EXT);
        pulse(IB_RD);
        fin("priority");
        pulse(EN_DMA);
        chk("request idle", 0, p6);
        pulse(P2_WR);
        chk("request raised", 1, p6);
        u_host.access(1'b1, 1'b1, 1'b0);
        chk("acked write", 16'h0001, {p6, in_full});
        pulse(P2_WR);
        u_host.access(1'b0, 1'b1, 1'b0);
        chk("acked read", 0, p6);
        pulse(P2_WR);
        pulse(EN_DMA);
        chk("cleared by enable", 0, p6);
        fin("dma");
        u_host.set_step(1'b0);
        one_insn();
        chk("halted", 16'h0003, {halt, sync});
        u_host.release_step();
        tick(4);
        chk("released", 0, halt);
        one_insn();
        chk("halted again", 1, halt);
        u_host.set_step(1'b1);
        tick(6);
        chk("run mode", 0, halt);
        pulse(EN_EXT);
        reset_dut();
        chk("pins after second reset", 16'h0007, {p4, p5, p6});
        chk("timer flag after second reset", 0, tflag);
        u_host.access(1'b1, 1'b0, 1'b0);
        wcall(3'h0);
        fin("step and reset");
        print_verdict();
    end
endmodule
